// ==== fifo_reset_config_pkg.sv ====
// shared constants and carriers for the fifo reset and configuration block
// assumes one 50 mhz system clock; port clocks arrive as sampled inputs
package fifo_reset_config_pkg;

  localparam int unsigned OFFSET_W      = 13;
  localparam int unsigned SERIAL_BITS   = 26;
  localparam int unsigned EDGE_CNT_W    = 3;
  localparam int unsigned BIT_CNT_W     = 5;
  localparam int unsigned HOLD_EDGES    = 4;
  localparam int unsigned READY_DELAY   = 2;
  localparam int unsigned PARALLEL_LDS  = 2;

  localparam logic [EDGE_CNT_W-1:0] HOLD_EDGES_C  = 3'h4;
  localparam logic [EDGE_CNT_W-1:0] READY_DELAY_C = 3'h2;
  localparam logic [1:0]            PAR_LOADS_C   = 2'h2;
  localparam logic [BIT_CNT_W-1:0]  SER_LAST_C    = 5'h19;

  localparam logic [OFFSET_W-1:0] PRESET_8    = 13'h0008;
  localparam logic [OFFSET_W-1:0] PRESET_16   = 13'h0010;
  localparam logic [OFFSET_W-1:0] PRESET_64   = 13'h0040;
  localparam logic [OFFSET_W-1:0] PRESET_256  = 13'h0100;
  localparam logic [OFFSET_W-1:0] PRESET_1024 = 13'h0400;

  // flag select patterns {high, mid, low}
  localparam logic [2:0] FS_64     = 3'h7;
  localparam logic [2:0] FS_16     = 3'h6;
  localparam logic [2:0] FS_8      = 3'h5;
  localparam logic [2:0] FS_256    = 3'h3;
  localparam logic [2:0] FS_1024   = 3'h1;
  localparam logic [2:0] FS_SERIAL = 3'h2;
  localparam logic [2:0] FS_PAR    = 3'h4;
  localparam logic [2:0] FS_PAR_IP = 3'h0;

  typedef enum logic [1:0] {
    PROG_PRESET,
    PROG_SERIAL,
    PROG_PARALLEL,
    PROG_PARALLEL_IP
  } prog_method_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_MODE_PICK,
    ST_READY_WAIT,
    ST_PROG,
    ST_RUN
  } ctrl_state_t;

  typedef struct packed {
    logic                full_input_ready_flag;
    logic                empty_output_ready_flag;
    logic                almost_empty_flag;
    logic                almost_full_flag;
    logic                mailbox_one_flag_n;
    logic                mailbox_two_flag_n;
  } flag_bus_t;

  typedef struct packed {
    logic                endian_select;
    logic                fall_through_mode;
    prog_method_t        method;
    logic                interleaved_parity_mode;
    logic [OFFSET_W-1:0] almost_empty_offset;
    logic [OFFSET_W-1:0] almost_full_offset;
  } config_t;

endpackage

// ==== fifo_reset_config_control.sv ====
// reset, partial reset, rewind and power-up configuration control
// assumes port clocks and reset pins are asynchronous inputs sampled on clk;
// the data path reads the pointer clear/rewind pulses and config outputs
`timescale 1ns/1ps

module fifo_reset_config_control (
  input  wire logic                                   clk,
  input  wire logic                                   reset_n,
  input  wire logic                                   port_a_clock,
  input  wire logic                                   port_b_clock,
  input  wire logic                                   master_reset_one_n,
  input  wire logic                                   master_reset_two_n,
  input  wire logic                                   partial_clear_n,
  input  wire logic                                   rewind_select,
  input  wire logic                                   endian_timing_select,
  input  wire logic                                   flag_select_high,
  input  wire logic                                   flag_select_mid_serial_en_n,
  input  wire logic                                   flag_select_low_serial_bit,
  input  wire logic                                   port_a_write,
  input  wire logic [fifo_reset_config_pkg::OFFSET_W:0] port_a_data,
  input  wire logic                                   long_word_width,
  output fifo_reset_config_pkg::flag_bus_t             flags,
  output fifo_reset_config_pkg::config_t               cfg,
  output logic                                        pointer_clear,
  output logic                                        read_pointer_rewind,
  output logic                                        msb_part_first,
  output logic                                        read_request_required,
  output logic                                        config_done
);

  localparam int unsigned SY = 10;
  localparam int unsigned CW = fifo_reset_config_pkg::BIT_CNT_W;
  localparam int unsigned OW = fifo_reset_config_pkg::OFFSET_W;
  // count after the last serial bit; first half of the bits goes to almost-full
  localparam logic [CW-1:0] SER_DONE_C = CW'(fifo_reset_config_pkg::SERIAL_BITS);
  localparam logic [CW-1:0] SER_HALF_C = CW'(OW);

  typedef struct packed {
    logic [SY-1:0]                              sync1;
    logic [SY-1:0]                              sync2;
    logic                                       port_a_clock_d;
    logic                                       port_b_clock_d;
    logic                                       rs1_d;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] full_a_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] full_b_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] part_a_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] part_b_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] rew_a_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] rew_b_cnt;
    logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] wait_cnt;
    logic                                       mode_a_seen;
    logic                                       mode_b_seen;
    logic                                       rewind_done;
    logic [1:0]                                 par_cnt;
    logic [fifo_reset_config_pkg::BIT_CNT_W-1:0] ser_cnt;
    logic [2:0]                                 fs_latched;
    logic                                       clear_pulse;
    logic                                       rewind_pulse;
    fifo_reset_config_pkg::ctrl_state_t         state;
    fifo_reset_config_pkg::flag_bus_t           flags;
    fifo_reset_config_pkg::config_t             cfg;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] edge_count(
    input logic                                       held,
    input logic                                       edge_seen,
    input logic [fifo_reset_config_pkg::EDGE_CNT_W-1:0] cnt
  );
    if (!held) begin
      edge_count = '0;
    end else if (edge_seen && cnt != fifo_reset_config_pkg::HOLD_EDGES_C) begin
      edge_count = cnt + 3'h1;
    end else begin
      edge_count = cnt;
    end
  endfunction

  logic [SY-1:0] raw_in;
  assign raw_in = {port_a_clock, port_b_clock, master_reset_one_n, master_reset_two_n,
                   partial_clear_n, rewind_select, endian_timing_select, flag_select_high,
                   flag_select_mid_serial_en_n, flag_select_low_serial_bit};

  always_comb begin
    logic port_a_clock_s;
    logic port_b_clock_s;
    logic rs1_s;
    logic rs2_s;
    logic shr_s;
    logic rsel_s;
    logic ets_s;
    logic fsh_s;
    logic fsm_s;
    logic fsl_s;
    logic a_rise;
    logic b_rise;
    logic full_low;
    logic part_low;
    logic rew_low;
    logic full_ok;
    logic part_ok;
    logic [2:0] fs;
    nxt_st = st_ff;
    {port_a_clock_s, port_b_clock_s, rs1_s, rs2_s, shr_s, rsel_s, ets_s, fsh_s, fsm_s, fsl_s} = st_ff.sync2;
    nxt_st.sync1 = raw_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.port_a_clock_d = port_a_clock_s;
    nxt_st.port_b_clock_d = port_b_clock_s;
    nxt_st.rs1_d = rs1_s;
    nxt_st.clear_pulse = 1'b0;
    nxt_st.rewind_pulse = 1'b0;
    a_rise = port_a_clock_s && !st_ff.port_a_clock_d;
    b_rise = port_b_clock_s && !st_ff.port_b_clock_d;
    full_low = !rs1_s || !rs2_s;
    part_low = !shr_s && !rsel_s;
    rew_low = !shr_s && rsel_s;
    fs = st_ff.fs_latched;

    nxt_st.full_a_cnt = edge_count(full_low, a_rise, st_ff.full_a_cnt);
    nxt_st.full_b_cnt = edge_count(full_low, b_rise, st_ff.full_b_cnt);
    nxt_st.part_a_cnt = edge_count(part_low, a_rise, st_ff.part_a_cnt);
    nxt_st.part_b_cnt = edge_count(part_low, b_rise, st_ff.part_b_cnt);
    nxt_st.rew_a_cnt = edge_count(rew_low, a_rise, st_ff.rew_a_cnt);
    nxt_st.rew_b_cnt = edge_count(rew_low, b_rise, st_ff.rew_b_cnt);
    full_ok = st_ff.full_a_cnt == fifo_reset_config_pkg::HOLD_EDGES_C &&
              st_ff.full_b_cnt == fifo_reset_config_pkg::HOLD_EDGES_C;
    part_ok = st_ff.part_a_cnt == fifo_reset_config_pkg::HOLD_EDGES_C &&
              st_ff.part_b_cnt == fifo_reset_config_pkg::HOLD_EDGES_C;

    // mailbox flags follow their own master reset
    if (!rs1_s) begin
      nxt_st.flags.mailbox_one_flag_n = 1'b1;
    end
    if (!rs2_s) begin
      nxt_st.flags.mailbox_two_flag_n = 1'b1;
    end

    // rewind of the read pointer only
    if (!rew_low) begin
      nxt_st.rewind_done = 1'b0;
    end else if (st_ff.rew_a_cnt == fifo_reset_config_pkg::HOLD_EDGES_C &&
                 st_ff.rew_b_cnt == fifo_reset_config_pkg::HOLD_EDGES_C &&
                 !st_ff.rewind_done) begin
      nxt_st.rewind_pulse = 1'b1;
      nxt_st.rewind_done = 1'b1;
    end

    if (full_ok || part_ok) begin
      nxt_st.state = fifo_reset_config_pkg::ST_RESET;
      nxt_st.clear_pulse = 1'b1;
      nxt_st.flags.full_input_ready_flag = 1'b0;
      nxt_st.flags.empty_output_ready_flag = 1'b0;
      nxt_st.flags.almost_empty_flag = 1'b0;
      nxt_st.flags.almost_full_flag = 1'b1;
      if (part_ok) begin
        nxt_st.flags.mailbox_one_flag_n = 1'b1;
        nxt_st.flags.mailbox_two_flag_n = 1'b1;
      end
      nxt_st.wait_cnt = '0;
      nxt_st.mode_a_seen = 1'b0;
      nxt_st.mode_b_seen = 1'b0;
    end

    // rising edge of first master reset latches configuration
    if (rs1_s && !st_ff.rs1_d && st_ff.state == fifo_reset_config_pkg::ST_RESET) begin
      fs = {fsh_s, fsm_s, fsl_s};
      nxt_st.fs_latched = fs;
      nxt_st.cfg.endian_select = ets_s;
      nxt_st.cfg.interleaved_parity_mode = 1'b0;
      nxt_st.cfg.method = fifo_reset_config_pkg::PROG_PRESET;
      if (fs == fifo_reset_config_pkg::FS_64) begin
        nxt_st.cfg.almost_empty_offset = fifo_reset_config_pkg::PRESET_64;
        nxt_st.cfg.almost_full_offset = fifo_reset_config_pkg::PRESET_64;
      end else if (fs == fifo_reset_config_pkg::FS_16) begin
        nxt_st.cfg.almost_empty_offset = fifo_reset_config_pkg::PRESET_16;
        nxt_st.cfg.almost_full_offset = fifo_reset_config_pkg::PRESET_16;
      end else if (fs == fifo_reset_config_pkg::FS_8) begin
        nxt_st.cfg.almost_empty_offset = fifo_reset_config_pkg::PRESET_8;
        nxt_st.cfg.almost_full_offset = fifo_reset_config_pkg::PRESET_8;
      end else if (fs == fifo_reset_config_pkg::FS_256) begin
        nxt_st.cfg.almost_empty_offset = fifo_reset_config_pkg::PRESET_256;
        nxt_st.cfg.almost_full_offset = fifo_reset_config_pkg::PRESET_256;
      end else if (fs == fifo_reset_config_pkg::FS_1024) begin
        nxt_st.cfg.almost_empty_offset = fifo_reset_config_pkg::PRESET_1024;
        nxt_st.cfg.almost_full_offset = fifo_reset_config_pkg::PRESET_1024;
      end else if (fs == fifo_reset_config_pkg::FS_SERIAL) begin
        nxt_st.cfg.method = fifo_reset_config_pkg::PROG_SERIAL;
      end else if (fs == fifo_reset_config_pkg::FS_PAR) begin
        nxt_st.cfg.method = fifo_reset_config_pkg::PROG_PARALLEL;
      end else begin
        nxt_st.cfg.method = fifo_reset_config_pkg::PROG_PARALLEL_IP;
        nxt_st.cfg.interleaved_parity_mode = 1'b1;
      end
      nxt_st.par_cnt = '0;
      nxt_st.ser_cnt = '0;
      nxt_st.state = fifo_reset_config_pkg::ST_MODE_PICK;
    end else if (!full_low && !part_low) begin
      case (st_ff.state)
        fifo_reset_config_pkg::ST_RESET: begin
          // partial reset release keeps cfg untouched
          if (st_ff.clear_pulse == 1'b0 && !part_ok && st_ff.wait_cnt == '0 &&
              !st_ff.flags.full_input_ready_flag) begin
            nxt_st.state = fifo_reset_config_pkg::ST_READY_WAIT;
          end
        end
        fifo_reset_config_pkg::ST_MODE_PICK: begin
          if (a_rise) begin
            nxt_st.mode_a_seen = 1'b1;
          end
          if (b_rise) begin
            nxt_st.mode_b_seen = 1'b1;
          end
          if ((st_ff.mode_a_seen || a_rise) && (st_ff.mode_b_seen || b_rise)) begin
            nxt_st.cfg.fall_through_mode = !ets_s;
            nxt_st.state = fifo_reset_config_pkg::ST_READY_WAIT;
            nxt_st.wait_cnt = a_rise ? 3'h1 : 3'h0;
          end else if (a_rise) begin
            nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
          end
        end
        fifo_reset_config_pkg::ST_READY_WAIT: begin
          if (a_rise) begin
            nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
          end
          if (st_ff.wait_cnt >= fifo_reset_config_pkg::READY_DELAY_C) begin
            if (st_ff.cfg.method == fifo_reset_config_pkg::PROG_PRESET ||
                st_ff.par_cnt == fifo_reset_config_pkg::PAR_LOADS_C ||
                st_ff.ser_cnt == SER_DONE_C) begin
              nxt_st.flags.full_input_ready_flag = 1'b1;
              nxt_st.state = fifo_reset_config_pkg::ST_RUN;
            end else begin
              nxt_st.state = fifo_reset_config_pkg::ST_PROG;
            end
          end
        end
        fifo_reset_config_pkg::ST_PROG: begin
          if (st_ff.cfg.method == fifo_reset_config_pkg::PROG_SERIAL) begin
            if (a_rise && !fsm_s && st_ff.ser_cnt != SER_DONE_C) begin
              nxt_st.cfg.almost_full_offset = st_ff.ser_cnt < SER_HALF_C ?
                {st_ff.cfg.almost_full_offset[OW-2:0], fsl_s} :
                st_ff.cfg.almost_full_offset;
              nxt_st.cfg.almost_empty_offset = st_ff.ser_cnt >= SER_HALF_C ?
                {st_ff.cfg.almost_empty_offset[OW-2:0], fsl_s} :
                st_ff.cfg.almost_empty_offset;
              nxt_st.ser_cnt = st_ff.ser_cnt + 5'h1;
            end else if (a_rise && st_ff.ser_cnt == SER_DONE_C) begin
              // ready rises on the port a edge after the last bit
              nxt_st.flags.full_input_ready_flag = 1'b1;
              nxt_st.state = fifo_reset_config_pkg::ST_RUN;
            end
          end else if (a_rise && port_a_write) begin
            if (st_ff.par_cnt == 2'h0) begin
              nxt_st.cfg.almost_full_offset = st_ff.cfg.interleaved_parity_mode ?
                {port_a_data[13:9], port_a_data[7:0]} : port_a_data[12:0];
            end else begin
              nxt_st.cfg.almost_empty_offset = st_ff.cfg.interleaved_parity_mode ?
                {port_a_data[13:9], port_a_data[7:0]} : port_a_data[12:0];
            end
            nxt_st.par_cnt = st_ff.par_cnt + 2'h1;
            if (st_ff.par_cnt == 2'h1) begin
              nxt_st.flags.full_input_ready_flag = 1'b1;
              nxt_st.state = fifo_reset_config_pkg::ST_RUN;
            end
          end
        end
        default: begin
          nxt_st.state = fifo_reset_config_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags = st_ff.flags;
  assign cfg = st_ff.cfg;
  assign pointer_clear = st_ff.clear_pulse;
  assign read_pointer_rewind = st_ff.rewind_pulse;
  assign msb_part_first = st_ff.cfg.endian_select && !long_word_width;
  assign read_request_required = !st_ff.cfg.fall_through_mode;
  assign config_done = st_ff.state == fifo_reset_config_pkg::ST_RUN;

endmodule

// ==== fifo_reset_config_properties.sv ====
// assertions on the ports of the reset and configuration control
// assumes a bind to fifo_reset_config_control from the bench top file
`timescale 1ns/1ps

module fifo_reset_config_properties (
  input wire logic                             clk,
  input wire logic                             reset_n,
  input wire logic                             master_reset_one_n,
  input wire logic                             master_reset_two_n,
  input wire logic                             long_word_width,
  input wire fifo_reset_config_pkg::flag_bus_t flags,
  input wire fifo_reset_config_pkg::config_t   cfg,
  input wire logic                             pointer_clear,
  input wire logic                             read_pointer_rewind,
  input wire logic                             msb_part_first,
  input wire logic                             read_request_required,
  input wire logic                             config_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_mbox_one_set: assert property (
    !master_reset_one_n [*5] |-> flags.mailbox_one_flag_n) else $error("mailbox one flag low");
  a_mbox_two_set: assert property (
    !master_reset_two_n [*5] |-> flags.mailbox_two_flag_n) else $error("mailbox two flag low");
  a_clear_flag_state: assert property (
    pointer_clear |=> !flags.full_input_ready_flag && !flags.empty_output_ready_flag
      && !flags.almost_empty_flag && flags.almost_full_flag) else $error("flags wrong on clear");
  a_rewind_one_pulse: assert property (
    read_pointer_rewind |=> !read_pointer_rewind) else $error("rewind pulse too long");
  a_rewind_no_clear: assert property (
    read_pointer_rewind |-> !pointer_clear) else $error("rewind cleared pointers");
  a_endian_order: assert property (
    msb_part_first == (cfg.endian_select && !long_word_width)) else $error("byte order wrong");
  a_timing_mode: assert property (
    read_request_required == !cfg.fall_through_mode) else $error("read request mode wrong");
  a_ready_in_run: assert property (
    flags.full_input_ready_flag |-> config_done) else $error("input ready before run");
  a_cfg_held: assert property (
    config_done && $past(config_done) |-> $stable(cfg)) else $error("config changed in run");

  c_clear: cover property (pointer_clear);
  c_rewind: cover property (read_pointer_rewind);
  c_fall_through: cover property ($rose(config_done) && cfg.fall_through_mode);
endmodule

// ==== port_clock_model.sv ====
// free-running port a and port b clocks of the far-side buses
// assumes 1 ns units; edges kept away from the system clock edges
`timescale 1ns/1ps

module port_clock_model #(
  parameter int HALF_NS = 160
) (
  output logic port_a_clock,
  output logic port_b_clock
);
  initial begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b1;
    #7;
    forever begin
      #(HALF_NS);
      port_a_clock = ~port_a_clock;
      port_b_clock = ~port_b_clock;
    end
  end
endmodule

// ==== tb_fifo_reset_config_control.sv ====
// self-checking bench for the reset and configuration control
// assumes port_clock_model makes both port clocks; pins driven on clk falls
`timescale 1ns/1ps

module tb_fifo_reset_config_control;
  logic                             clk = 1'b0;
  logic                             reset_n = 1'b0;
  logic                             port_a_clock;
  logic                             port_b_clock;
  logic                             master_reset_one_n = 1'b1;
  logic                             master_reset_two_n = 1'b1;
  logic                             partial_clear_n = 1'b1;
  logic                             rewind_select = 1'b0;
  logic                             endian_timing_select = 1'b1;
  logic                             flag_select_high = 1'b1;
  logic                             flag_select_mid_serial_en_n = 1'b1;
  logic                             flag_select_low_serial_bit = 1'b1;
  logic                             port_a_write = 1'b0;
  logic [13:0]                      port_a_data = 14'h0000;
  logic                             long_word_width = 1'b0;
  fifo_reset_config_pkg::flag_bus_t flags;
  fifo_reset_config_pkg::config_t   cfg;
  fifo_reset_config_pkg::config_t   saved;
  logic                             pointer_clear;
  logic                             read_pointer_rewind;
  logic                             msb_part_first;
  logic                             read_request_required;
  logic                             config_done;
  logic [25:0]                      ser = {13'h0abc, 13'h0123};
  logic [13:0]                      d1 = 14'h2dab;
  logic [13:0]                      d2 = 14'h1357;
  logic [2:0]                       fs_tab [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  logic [12:0]                      off_tab [5] = '{13'h0040, 13'h0010, 13'h0008, 13'h0100, 13'h0400};
  int                               error_cnt = 0;
  int                               num_checks = 0;
  int                               clr_cnt = 0;
  int                               rew_cnt = 0;
  int                               k;
  int                               i;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (pointer_clear === 1'b1) clr_cnt++;
    if (read_pointer_rewind === 1'b1) rew_cnt++;
  end

  port_clock_model pcm (.port_a_clock(port_a_clock), .port_b_clock(port_b_clock));

  fifo_reset_config_control dut (
    .clk(clk), .reset_n(reset_n), .port_a_clock(port_a_clock), .port_b_clock(port_b_clock),
    .master_reset_one_n(master_reset_one_n), .master_reset_two_n(master_reset_two_n),
    .partial_clear_n(partial_clear_n), .rewind_select(rewind_select),
    .endian_timing_select(endian_timing_select), .flag_select_high(flag_select_high),
    .flag_select_mid_serial_en_n(flag_select_mid_serial_en_n),
    .flag_select_low_serial_bit(flag_select_low_serial_bit), .port_a_write(port_a_write),
    .port_a_data(port_a_data), .long_word_width(long_word_width), .flags(flags), .cfg(cfg),
    .pointer_clear(pointer_clear), .read_pointer_rewind(read_pointer_rewind),
    .msb_part_first(msb_part_first), .read_request_required(read_request_required),
    .config_done(config_done));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_a(input int n);
    repeat (n) @(posedge port_a_clock);
    repeat (5) @(negedge clk);
  endtask

  // both resets low together over seven port a rising edges, then mode level
  task automatic full_reset(input logic [2:0] fs, input logic endian, input logic std_mode);
    clr_cnt = 0;
    {flag_select_high, flag_select_mid_serial_en_n, flag_select_low_serial_bit} = fs;
    endian_timing_select = endian;
    master_reset_one_n = 1'b0;
    master_reset_two_n = 1'b0;
    wait_a(6);
    check("flags_reset", flags, 6'h07);
    check("clear_reset", clr_cnt > 0, 1'b1);
    @(posedge port_a_clock);
    @(negedge clk);
    master_reset_one_n = 1'b1;
    master_reset_two_n = 1'b1;
    repeat (3) @(negedge clk);
    endian_timing_select = std_mode;
  endtask

  task automatic pwrite(input logic [13:0] d);
    @(negedge port_a_clock);
    @(negedge clk);
    port_a_data = d;
    port_a_write = 1'b1;
    @(negedge port_a_clock);
    @(negedge clk);
    port_a_write = 1'b0;
  endtask

  initial begin
    #400us;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    for (k = 0; k < 5; k++) begin
      full_reset(fs_tab[k], k[0], k[1]);
      wait_a(1);
      check("flags_wait", flags, 6'h07);
      wait_a(2);
      check("flags_ready", flags, 6'h27);
      check("offsets", {cfg.almost_empty_offset, cfg.almost_full_offset}, {2{off_tab[k]}});
      check("method", cfg.method, fifo_reset_config_pkg::PROG_PRESET);
      check("endian", cfg.endian_select, k[0]);
      check("fall_through", cfg.fall_through_mode, !k[1]);
      check("read_req", read_request_required, k[1]);
      for (i = 0; i < 2; i++) begin
        long_word_width = i[0];
        @(negedge clk);
        check("msb_first", msb_part_first, k[0] & !i[0]);
      end
    end
    $display("test preset done");
    saved = cfg;
    clr_cnt = 0;
    partial_clear_n = 1'b0;
    wait_a(6);
    check("flags_partial", flags, 6'h07);
    check("clear_partial", clr_cnt > 0, 1'b1);
    partial_clear_n = 1'b1;
    wait_a(1);
    check("flags_pwait", flags, 6'h07);
    wait_a(2);
    check("flags_pready", flags, 6'h27);
    check("cfg_kept", cfg, saved);
    $display("test partial done");
    clr_cnt = 0;
    rew_cnt = 0;
    rewind_select = 1'b1;
    repeat (3) @(negedge clk);
    partial_clear_n = 1'b0;
    wait_a(6);
    partial_clear_n = 1'b1;
    wait_a(1);
    rewind_select = 1'b0;
    check("rewinds", rew_cnt, 1);
    check("clears", clr_cnt, 0);
    check("flags_rewind", flags, 6'h27);
    $display("test rewind done");
    for (k = 0; k < 2; k++) begin
      full_reset(k[0] ? 3'h0 : 3'h4, 1'b1, 1'b1);
      wait_a(4);
      check("ff_prog", flags.full_input_ready_flag, 1'b0);
      pwrite(d1);
      pwrite(d2);
      wait_a(2);
      check("ff_par", flags.full_input_ready_flag, 1'b1);
      check("af_par", cfg.almost_full_offset, k[0] ? {d1[13:9], d1[7:0]} : d1[12:0]);
      check("ae_par", cfg.almost_empty_offset, k[0] ? {d2[13:9], d2[7:0]} : d2[12:0]);
      check("method_par", {cfg.method, cfg.interleaved_parity_mode}, k[0] ?
        {fifo_reset_config_pkg::PROG_PARALLEL_IP, 1'b1} : {fifo_reset_config_pkg::PROG_PARALLEL, 1'b0});
    end
    $display("test parallel done");
    full_reset(3'h2, 1'b0, 1'b1);
    wait_a(4);
    for (i = 25; i >= 0; i--) begin
      if (i == 12) begin
        @(negedge port_a_clock);
        @(negedge clk);
        flag_select_mid_serial_en_n = 1'b1;
      end
      @(negedge port_a_clock);
      @(negedge clk);
      check("ff_ser", flags.full_input_ready_flag, 1'b0);
      flag_select_mid_serial_en_n = 1'b0;
      flag_select_low_serial_bit = ser[i];
    end
    @(negedge port_a_clock);
    @(negedge clk);
    flag_select_mid_serial_en_n = 1'b1;
    wait_a(2);
    check("ff_ser_done", flags.full_input_ready_flag, 1'b1);
    check("ser_offsets", {cfg.almost_full_offset, cfg.almost_empty_offset}, ser);
    check("method_ser", cfg.method, fifo_reset_config_pkg::PROG_SERIAL);
    $display("test serial done");
    end_sim();
  end
endmodule

bind fifo_reset_config_control fifo_reset_config_properties chk (
  .clk(clk), .reset_n(reset_n), .master_reset_one_n(master_reset_one_n),
  .master_reset_two_n(master_reset_two_n), .long_word_width(long_word_width), .flags(flags),
  .cfg(cfg), .pointer_clear(pointer_clear), .read_pointer_rewind(read_pointer_rewind),
  .msb_part_first(msb_part_first), .read_request_required(read_request_required),
  .config_done(config_done));
